// *** verilog/dual_dac_datapath.sv ***
// dual converter digital core: byte link, coarse mixer, offsets,
// thermal sampling and static controls behind an ahb-lite slave
// assumes one ahb master, link pins asynchronous to hclk
`timescale 1ns/1ps
`include "dual_dac_defines.svh"

// What this block does
// - coarse mixer only acts while the interpolation filter is enabled
// - two-bit select: none, half rate, plus quarter, minus quarter
// - plus quarter: A gives +A,-B,-A,+B; B gives +B,+A,-B,-A
// - minus quarter: A gives +A,+B,-A,-B; B gives +B,-A,-B,+A
// - half rate keeps channels apart, negating every second sample
// - half rate turns the filter into an inverted high-pass response
// - two independent 13-bit signed offsets, -4096 to 4095
// - writing the load register applies all four offset registers at once
// - offset added to the sample, both aligned at the lsb
// - temperature is 8-bit signed celsius from sar, scaled and limited
// - with sensing enabled every serial access converts, sleep included
// - first eight serial clocks convert, valid eighth fall, out ninth rise
// - temperature shifted out only on reads of the thermal status register
// - five sleep bits: two converters, two clock paths, clock receiver
// - converter-only sleep settles in 90 us, full sleep takes 1 ms
// - per-converter 4-bit gain; full scale is code plus one times bias
// - reference bit low keeps bandgap on, high selects external reference
// - two 16-bit channels as bytes on both strobe edges, bit 0 lsb
// - frame marker sampled on strobe rising edges marks frame start
module dual_dac_datapath #(
   parameter int unsigned FULL_WAKE_CYCLES = `FULL_WAKE_CYC
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output      logic               hreadyout,
   output      logic [31:0]        hrdata,
   output      logic               hresp,
   input  wire logic               sample_byte_strobe,
   input  wire logic [7:0]         sample_byte,
   input  wire logic               frame_marker,
   output      logic signed [15:0] out_a,
   output      logic signed [15:0] out_b,
   output      logic               out_valid,
   output      logic               interpolation_filter_enable,
   output      logic [4:0]         sleep_ctrl,
   output      logic [3:0]         coarse_gain_a,
   output      logic [3:0]         coarse_gain_b,
   output      logic [4:0]         full_scale_a,
   output      logic [4:0]         full_scale_b,
   output      logic               bandgap_enable,
   input  wire logic               serial_clock,
   input  wire logic               serial_select_low,
   input  wire logic               serial_data_in,
   input  wire logic               thermal_compare,
   output      logic [7:0]         thermal_trial_code,
   output      logic               thermal_sdo,
   output      logic               thermal_sdo_oe
);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
      if (v > 18'sh07FFF)
         sat16 = 16'sh7FFF;
      else if (v < 18'sh38000)
         sat16 = 16'sh8000;
      else
         sat16 = v[15:0];
   endfunction : sat16

   // negating the most negative code would wrap, so clip it
   function automatic logic signed [15:0] neg16(input logic signed [15:0] x);
      neg16 = sat16(-{{2{x[15]}}, x});
   endfunction : neg16

   // ************************************************************
   // ahb-lite slave
   // ************************************************************
   logic [7:0]  addr_q;
   logic        wr_q;
   logic        interp_en;
   logic [1:0]  mix_sel;
   logic [7:0]  off_a_low;
   logic [4:0]  off_a_high;
   logic [7:0]  off_b_low;
   logic [4:0]  off_b_high;
   logic signed [12:0] act_off_a;
   logic signed [12:0] act_off_b;
   logic        tsense_en;
   logic        extref_en;
   logic [7:0]  therm_value;
   logic        frame_seen;
   logic [31:0] settle_cnt;
   logic        req;

   assign req       = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 8'h00;
         wr_q   <= 1'b0;
      end else begin
         addr_q <= haddr[7:0];
         wr_q   <= req & hwrite & (hsize == 3'h2);
      end
   end

   // read data fetched in the address phase; unmapped reads give zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (req && !hwrite) begin
         case (haddr[7:0])
            `MIX_CTRL_OFS:   hrdata <= {29'h0, mix_sel, interp_en};
            `OFS_LOAD_OFS:   hrdata <= {24'h0, off_a_low};
            `OFS_A_HIGH_OFS: hrdata <= {27'h0, off_a_high};
            `OFS_B_LOW_OFS:  hrdata <= {24'h0, off_b_low};
            `OFS_B_HIGH_OFS: hrdata <= {27'h0, off_b_high};
            `THERM_STAT_OFS: hrdata <= {24'h0, therm_value};
            `THERM_CTRL_OFS: hrdata <= {31'h0, tsense_en};
            `REF_CTRL_OFS:   hrdata <= {31'h0, extref_en};
            `GAIN_OFS:       hrdata <= {24'h0, coarse_gain_b, coarse_gain_a};
            `SLEEP_OFS:      hrdata <= {27'h0, sleep_ctrl};
            `STATUS_OFS:     hrdata <= {30'h0, frame_seen, settle_cnt != 32'h0};
            default:         hrdata <= 32'h00000000;
         endcase
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interp_en <= 1'b0;
         mix_sel   <= 2'h0;
      end else if (wr_q && addr_q == `MIX_CTRL_OFS) begin
         interp_en <= hwdata[`INTERP_EN_BIT];
         mix_sel   <= hwdata[`MIX_SEL_MSB:`MIX_SEL_LSB];
      end
   end
   assign interpolation_filter_enable = interp_en;

   // staged offsets only reach the adder on a load-register write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         off_a_low  <= 8'h00;
         off_a_high <= 5'h00;
         off_b_low  <= 8'h00;
         off_b_high <= 5'h00;
         act_off_a  <= 13'sh0000;
         act_off_b  <= 13'sh0000;
      end else if (wr_q) begin
         case (addr_q)
            `OFS_LOAD_OFS: begin
               off_a_low <= hwdata[7:0];
               act_off_a <= {off_a_high, hwdata[7:0]};
               act_off_b <= {off_b_high, off_b_low};
            end
            `OFS_A_HIGH_OFS: off_a_high <= hwdata[4:0];
            `OFS_B_LOW_OFS:  off_b_low  <= hwdata[7:0];
            `OFS_B_HIGH_OFS: off_b_high <= hwdata[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tsense_en <= 1'b0;
         extref_en <= 1'b0;
      end else if (wr_q) begin
         if (addr_q == `THERM_CTRL_OFS)
            tsense_en <= hwdata[`TSENSE_EN_BIT];
         if (addr_q == `REF_CTRL_OFS)
            extref_en <= hwdata[`EXTREF_EN_BIT];
      end
   end
   assign bandgap_enable = ~extref_en;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         coarse_gain_a <= `GAIN_RST;
         coarse_gain_b <= `GAIN_RST;
         full_scale_a  <= {1'b0, `GAIN_RST} + 5'h01;
         full_scale_b  <= {1'b0, `GAIN_RST} + 5'h01;
      end else if (wr_q && addr_q == `GAIN_OFS) begin
         coarse_gain_a <= hwdata[`GAIN_A_MSB:`GAIN_A_LSB];
         coarse_gain_b <= hwdata[`GAIN_B_MSB:`GAIN_B_LSB];
         full_scale_a  <= {1'b0, hwdata[`GAIN_A_MSB:`GAIN_A_LSB]} + 5'h01;
         full_scale_b  <= {1'b0, hwdata[`GAIN_B_MSB:`GAIN_B_LSB]} + 5'h01;
      end
   end

   // ************************************************************
   // sleep control and settle timer
   // ************************************************************
   // a change touching clock paths or receiver waits the long time
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_ctrl <= `SLEEP_RST;
         settle_cnt <= 32'h0;
      end else if (wr_q && addr_q == `SLEEP_OFS
                   && hwdata[`SLEEP_MSB:0] != sleep_ctrl) begin
         sleep_ctrl <= hwdata[`SLEEP_MSB:0];
         if (hwdata[`SLEEP_MSB:`SLEEP_DAC_MSB+1]
             == sleep_ctrl[`SLEEP_MSB:`SLEEP_DAC_MSB+1])
            settle_cnt <= 32'(`DAC_WAKE_CYC);
         else
            settle_cnt <= FULL_WAKE_CYCLES;
      end else if (settle_cnt != 32'h0) begin
         settle_cnt <= settle_cnt - 32'h1;
      end
   end

   // ************************************************************
   // byte link capture
   // ************************************************************
   logic [1:0] strobe_sync;
   logic       strobe_prev;
   logic [7:0] byte_meta;
   logic [7:0] byte_sync;
   logic [1:0] frame_sync;
   logic       strobe_rise;
   logic       strobe_edge;
   logic [1:0] byte_idx;
   logic [7:0] a_high;
   logic [7:0] a_low;
   logic [7:0] b_high;
   logic [1:0] mix_phase;
   logic       frame_now;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strobe_sync <= 2'h0;
         strobe_prev <= 1'b0;
         byte_meta   <= 8'h00;
         byte_sync   <= 8'h00;
         frame_sync  <= 2'h0;
      end else begin
         strobe_sync <= {strobe_sync[0], sample_byte_strobe};
         strobe_prev <= strobe_sync[1];
         byte_meta   <= sample_byte;
         byte_sync   <= byte_meta;
         frame_sync  <= {frame_sync[0], frame_marker};
      end
   end

   assign strobe_rise = strobe_sync[1] & ~strobe_prev;
   assign strobe_edge = strobe_sync[1] ^ strobe_prev;
   assign frame_now   = strobe_rise & frame_sync[1];

   // marker on a rising edge makes that byte the first of a pair
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byte_idx   <= 2'h0;
         a_high     <= 8'h00;
         a_low      <= 8'h00;
         b_high     <= 8'h00;
         frame_seen <= 1'b0;
      end else if (strobe_edge) begin
         if (frame_now) begin
            frame_seen <= 1'b1;
            a_high     <= byte_sync;
            byte_idx   <= 2'h1;
         end else begin
            case (byte_idx)
               2'h0:    a_high <= byte_sync;
               2'h1:    a_low  <= byte_sync;
               2'h2:    b_high <= byte_sync;
               default: ;
            endcase
            byte_idx <= byte_idx + 2'h1;
         end
      end
   end

   // ************************************************************
   // coarse mixer and offset adder
   // ************************************************************
   logic signed [15:0] pair_a;
   logic signed [15:0] pair_b;
   logic signed [15:0] next_a;
   logic signed [15:0] next_b;
   dual_dac_pkg::mix_mode_t mode;
   logic               pair_done;

   assign pair_a    = {a_high, a_low};
   assign pair_b    = {b_high, byte_sync};
   assign pair_done = strobe_edge & ~frame_now & (byte_idx == 2'h3);
   // without the filter there is no stage to host the mixer
   assign mode = interp_en ? dual_dac_pkg::mix_mode_t'(mix_sel)
                           : dual_dac_pkg::MIX_NONE;

   always_comb begin
      next_a = pair_a;
      next_b = pair_b;
      case (mode)
         dual_dac_pkg::MIX_HALF: begin
            if (mix_phase[0]) begin
               next_a = neg16(pair_a);
               next_b = neg16(pair_b);
            end
         end
         dual_dac_pkg::MIX_POS_QTR: begin
            case (mix_phase)
               2'h1: begin next_a = neg16(pair_b); next_b = pair_a;         end
               2'h2: begin next_a = neg16(pair_a); next_b = neg16(pair_b);  end
               2'h3: begin next_a = pair_b;        next_b = neg16(pair_a);  end
               default: ;
            endcase
         end
         dual_dac_pkg::MIX_NEG_QTR: begin
            case (mix_phase)
               2'h1: begin next_a = pair_b;        next_b = neg16(pair_a);  end
               2'h2: begin next_a = neg16(pair_a); next_b = neg16(pair_b);  end
               2'h3: begin next_a = neg16(pair_b); next_b = pair_a;         end
               default: ;
            endcase
         end
         default: ;
      endcase
   end

   // mixer phase restarts at each marker so sequences line up with frames
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mix_phase <= 2'h0;
         out_a     <= 16'sh0000;
         out_b     <= 16'sh0000;
         out_valid <= 1'b0;
      end else begin
         out_valid <= pair_done;
         if (frame_now)
            mix_phase <= 2'h0;
         else if (pair_done)
            mix_phase <= mix_phase + 2'h1;
         if (pair_done) begin
            out_a <= sat16({{2{next_a[15]}}, next_a}
                           + {{5{act_off_a[12]}}, act_off_a});
            out_b <= sat16({{2{next_b[15]}}, next_b}
                           + {{5{act_off_b[12]}}, act_off_b});
         end
      end
   end

   // ************************************************************
   // thermal sampling on the serial clock
   // ************************************************************
   logic [1:0] sclk_sync;
   logic       sclk_prev;
   logic [1:0] sel_sync;
   logic [1:0] sdi_sync;
   logic [1:0] cmp_sync;
   logic       sclk_rise;
   logic       sclk_fall;
   logic [4:0] sclk_cnt;
   logic [7:0] instr;
   logic [7:0] sar_mask;
   logic [7:0] shift_out;
   logic signed [9:0] scaled;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_sync <= 2'h0;
         sclk_prev <= 1'b0;
         sel_sync  <= 2'h3;
         sdi_sync  <= 2'h0;
         cmp_sync  <= 2'h0;
      end else begin
         sclk_sync <= {sclk_sync[0], serial_clock};
         sclk_prev <= sclk_sync[1];
         sel_sync  <= {sel_sync[0], serial_select_low};
         sdi_sync  <= {sdi_sync[0], serial_data_in};
         cmp_sync  <= {cmp_sync[0], thermal_compare};
      end
   end

   assign sclk_rise = sclk_sync[1] & ~sclk_prev & ~sel_sync[1];
   assign sclk_fall = ~sclk_sync[1] & sclk_prev & ~sel_sync[1];
   assign scaled    = $signed({2'h0, thermal_trial_code}) - $signed(`THERM_BIAS);

   // hclk samples the serial clock here and no sleep bit gates it, so it works while asleep
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_cnt           <= 5'h00;
         instr              <= 8'h00;
         sar_mask           <= `SAR_START;
         thermal_trial_code <= `SAR_START;
         therm_value        <= 8'h00;
         shift_out          <= 8'h00;
         thermal_sdo_oe     <= 1'b0;
      end else if (sel_sync[1]) begin
         sclk_cnt           <= 5'h00;
         sar_mask           <= `SAR_START;
         thermal_trial_code <= `SAR_START;
         thermal_sdo_oe     <= 1'b0;
      end else if (sclk_rise) begin
         if (sclk_cnt != 5'h1F)
            sclk_cnt <= sclk_cnt + 5'h01;
         if (sclk_cnt < 5'h08) begin
            instr    <= {instr[6:0], sdi_sync[1]};
            sar_mask <= sar_mask >> 1;
            if (tsense_en)
               thermal_trial_code <= (cmp_sync[1] ? thermal_trial_code
                                      : thermal_trial_code & ~sar_mask)
                                     | (sar_mask >> 1);
         end else if (sclk_cnt == 5'h08) begin
            if (instr[7] && instr[4:0] == `THERM_SER_ADDR) begin
               shift_out      <= therm_value;
               thermal_sdo_oe <= 1'b1;
            end
         end else begin
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end else if (sclk_fall && sclk_cnt == 5'h08 && tsense_en) begin
         if (scaled < $signed(`THERM_MIN))
            therm_value <= 8'(`THERM_MIN);
         else if (scaled > $signed(`THERM_MAX))
            therm_value <= 8'(`THERM_MAX);
         else
            therm_value <= scaled[7:0];
      end
   end
   assign thermal_sdo = shift_out[7];

endmodule : dual_dac_datapath

// *** verilog/dual_dac_defines.svh ***
// constants for the dual converter digital datapath
// assumes a 40 MHz bus clock and a word-aligned register map
`ifndef DUAL_DAC_DEFINES_SVH
`define DUAL_DAC_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define MIX_CTRL_OFS     8'h00
`define OFS_LOAD_OFS     8'h04
`define OFS_A_HIGH_OFS   8'h08
`define OFS_B_LOW_OFS    8'h0C
`define OFS_B_HIGH_OFS   8'h10
`define THERM_STAT_OFS   8'h14
`define THERM_CTRL_OFS   8'h18
`define REF_CTRL_OFS     8'h1C
`define GAIN_OFS         8'h20
`define SLEEP_OFS        8'h24
`define STATUS_OFS       8'h28

// ************************************************************
// field positions
// ************************************************************
`define INTERP_EN_BIT    0
`define MIX_SEL_LSB      1
`define MIX_SEL_MSB      2
`define TSENSE_EN_BIT    0
`define EXTREF_EN_BIT    0
`define GAIN_A_LSB       0
`define GAIN_A_MSB       3
`define GAIN_B_LSB       4
`define GAIN_B_MSB       7
`define SLEEP_DAC_MSB    1
`define SLEEP_MSB        4

// ************************************************************
// reset values
// ************************************************************
`define GAIN_RST         4'hF
`define SLEEP_RST        5'h00

// ************************************************************
// thermal sensing
// ************************************************************
`define THERM_SER_ADDR   5'h05
`define THERM_BIAS       10'h040
`define THERM_MIN        10'h3D8
`define THERM_MAX        10'h07D
`define SAR_START        8'h80

// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ          40
`define DAC_WAKE_US      90
`define DAC_WAKE_CYC     (`DAC_WAKE_US * `CLK_MHZ)
`define FULL_WAKE_MS     1
`define FULL_WAKE_CYC    (`FULL_WAKE_MS * 1000 * `CLK_MHZ)

`endif

// *** verilog/dual_dac_pkg.sv ***
// types shared by the dual converter datapath
// assumes nothing of its surroundings
package dual_dac_pkg;
   typedef enum logic [1:0] {
      MIX_NONE    = 2'h0,
      MIX_HALF    = 2'h1,
      MIX_POS_QTR = 2'h2,
      MIX_NEG_QTR = 2'h3
   } mix_mode_t;
endpackage : dual_dac_pkg

// *** verification/dual_dac_datapath_monitor.sv ***
// port assertions for the dual converter datapath
// assumes it is bound onto dual_dac_datapath, one bus master
`timescale 1ns/1ps
module dual_dac_datapath_monitor (
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hsel,
   input wire logic [31:0]        haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic [31:0]        hwdata,
   input wire logic               hready,
   input wire logic signed [15:0] out_a,
   input wire logic signed [15:0] out_b,
   input wire logic               out_valid,
   input wire logic [4:0]         sleep_ctrl,
   input wire logic [3:0]         coarse_gain_a,
   input wire logic [3:0]         coarse_gain_b,
   input wire logic [4:0]         full_scale_a,
   input wire logic [4:0]         full_scale_b,
   input wire logic               bandgap_enable
);
   // ************************************************
   // write in its data phase, FF when none
   // ************************************************
   logic [7:0] wr_hit;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_hit <= 8'hFF;
      else
         wr_hit <= (hsel && hready && htrans[1] && hwrite) ? haddr[7:0] : 8'hFF;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_wr(logic [7:0] a);
      hsel && hready && htrans[1] && hwrite && haddr[7:0] == a ##1 hready;
   endsequence
   chk_scale_a: assert property (full_scale_a == {1'b0, coarse_gain_a} + 5'h01)
      else $error("full scale a is not gain plus one");
   chk_scale_b: assert property (full_scale_b == {1'b0, coarse_gain_b} + 5'h01)
      else $error("full scale b is not gain plus one");
   chk_sleep_wr: assert property (s_wr(8'h24) |=> sleep_ctrl == $past(hwdata[4:0]))
      else $error("sleep bits differ from written word");
   chk_sleep_cause: assert property ($changed(sleep_ctrl) |-> $past(wr_hit) == 8'h24)
      else $error("sleep bits moved without a write");
   chk_gain_cause: assert property ($changed({coarse_gain_a, coarse_gain_b}) |->
      $past(wr_hit) == 8'h20) else $error("gain moved without a write");
   chk_ref_wr: assert property (s_wr(8'h1C) |=> bandgap_enable == !$past(hwdata[0]))
      else $error("bandgap enable differs from written bit");
   chk_valid_pulse: assert property (out_valid |=> !out_valid)
      else $error("out valid longer than one cycle");
   chk_out_paired: assert property ($changed({out_a, out_b}) |-> out_valid)
      else $error("outputs moved without out valid");
endmodule : dual_dac_datapath_monitor

bind dual_dac_datapath dual_dac_datapath_monitor i_dual_dac_datapath_monitor (.*);

// *** verification/sample_byte_source.sv ***
// byte source standing at the far side of the sample link
// assumes the bench calls send_pair; the strobe idles between pairs
`timescale 1ns/1ps
module sample_byte_source (
   output logic       sample_byte_strobe,
   output logic [7:0] sample_byte,
   output logic       frame_marker
);
   initial begin
      sample_byte_strobe = 1'b0;
      sample_byte = 8'h00;
      frame_marker = 1'b0;
   end
   // one byte per strobe edge, channel a high byte first
   task automatic send_pair(input logic [15:0] a, input logic [15:0] b, input logic mark);
      logic [31:0] w;
      w = {a, b};
      for (int i = 0; i < 4; i++) begin
         sample_byte = w[31 - 8 * i -: 8];
         frame_marker = mark && i == 0; // half a period, over a rise
         #10 sample_byte_strobe = ~sample_byte_strobe;
         #90;
      end
      frame_marker = 1'b0;
      sample_byte = ~sample_byte; // inverted, so no stale byte is left
   endtask : send_pair
endmodule : sample_byte_source

// *** verification/dual_dac_datapath_test.sv ***
// self-checking bench for the dual converter datapath
// assumes the byte source model and the bound checker
`timescale 1ns/1ps
module dual_dac_datapath_test;
   logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, oe;
   logic               interpolation_filter_enable, bandgap_enable, out_valid;
   logic               sample_byte_strobe, frame_marker, thermal_sdo, thermal_sdo_oe;
   logic               serial_clock, serial_select_low, serial_data_in, thermal_compare;
   logic [31:0]        haddr, hwdata, hrdata, rd;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic [7:0]         sample_byte, thermal_trial_code, got;
   logic [4:0]         sleep_ctrl, full_scale_a, full_scale_b;
   logic [3:0]         coarse_gain_a, coarse_gain_b;
   logic signed [15:0] out_a, out_b, qa[$], qb[$];
   logic [2:0]         modes[5] = '{3'h1, 3'h3, 3'h5, 3'h7, 3'h6};
   int                 miscompares = 0;
   int                 comparisons = 0;
   assign hready = hreadyout;
   dual_dac_datapath #(.FULL_WAKE_CYCLES(50)) i_dual_dac_datapath (.*);
   sample_byte_source i_sample_byte_source (.*);
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (out_valid === 1'b1) begin
         qa.push_back(out_a);
         qb.push_back(out_b);
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   // ************************************************
   // bus and link drivers
   // ************************************************
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic run(input logic [15:0] a, input logic [15:0] b, input int n);
      qa.delete();
      qb.delete();
      for (int k = 0; k < n; k++)
         i_sample_byte_source.send_pair(a, b, k == 0);
      repeat (12) @(posedge hclk);
      check("pair count", qa.size(), n);
   endtask : run
   task automatic serial_frame(input logic [7:0] instr, input logic cmp);
      thermal_compare <= cmp;
      serial_select_low <= 1'b0;
      for (int i = 0; i < 17; i++) begin
         serial_data_in <= instr[7 - (i % 8)];
         repeat (20) @(posedge hclk);
         if (i == 9)
            oe = thermal_sdo_oe;
         if (i > 8)
            got[16 - i] = thermal_sdo;
         serial_clock <= 1'b1;
         repeat (20) @(posedge hclk);
         serial_clock <= 1'b0;
      end
      repeat (20) @(posedge hclk);
      serial_select_low <= 1'b1;
      repeat (40) @(posedge hclk);
   endtask : serial_frame
   task automatic test_regs;
      check("reset gains", {full_scale_a, coarse_gain_b, coarse_gain_a}, 32'h10FF);
      check("reset ref sleep", {bandgap_enable, sleep_ctrl}, 32'h20);
      bus(8'h20, 1'b1, 32'h5A);
      bus(8'h1C, 1'b1, 32'h1);
      bus(8'h24, 1'b1, 32'h1F);
      bus(8'h28, 1'b0, 32'h0);
      check("settling", rd[0], 32'h1);
      bus(8'h3C, 1'b0, 32'h0);
      check("unmapped read", rd | hresp, 32'h0);
      repeat (60) @(posedge hclk);
      bus(8'h28, 1'b0, 32'h0);
      check("settled", rd[0], 32'h0);
      bus(8'h20, 1'b0, 32'h0);
      check("gain read", rd, 32'h5A);
      check("full scales", {full_scale_b, full_scale_a}, 32'hCB);
      check("ref sleep", {bandgap_enable, sleep_ctrl}, 32'h1F);
   endtask : test_regs
   task automatic test_mix(input logic [2:0] ctrl);
      logic signed [15:0] a, b, ea, eb;
      a = 16'h1000;
      b = 16'h0300;
      bus(8'h00, 1'b1, {29'h0, ctrl});
      run(a, b, 4);
      check("filter on", interpolation_filter_enable, ctrl[0]);
      for (int k = 0; k < 4; k++) begin
         {ea, eb} = {a, b};
         if (ctrl[0] && (ctrl[2:1] == 2'h1 ? k[0] : ctrl[2] && k == 2))
            {ea, eb} = {-a, -b};
         if (ctrl[0] && ctrl[2] && k[0])
            {ea, eb} = ((k == 1) ^ ctrl[1]) ? {-b, a} : {b, -a};
         check("mixed", {qa[k], qb[k]}, {ea, eb});
      end
   endtask : test_mix
   task automatic test_offset;
      bus(8'h00, 1'b1, 32'h0);
      bus(8'h08, 1'b1, 32'h0F);
      bus(8'h0C, 1'b1, 32'h00);
      bus(8'h10, 1'b1, 32'h10);
      run(16'h7FF0, 16'h0010, 1);
      check("offset held", {qa[0], qb[0]}, 32'h7FF00010);
      bus(8'h04, 1'b1, 32'hFF);
      run(16'h7FF0, 16'h0010, 1);
      check("offset on", {qa[0], qb[0]}, 32'h7FFFF010);
   endtask : test_offset
   task automatic test_thermal;
      bus(8'h18, 1'b1, 32'h1);
      serial_frame(8'h85, 1'b1);
      check("hot temp", {oe, got}, 32'h17D);
      serial_frame(8'h85, 1'b0);
      check("cold temp", got, 32'hD8);
      serial_frame(8'h05, 1'b1);
      bus(8'h14, 1'b0, 32'h0);
      check("write frame", {oe, rd[7:0]}, 32'h07D);
   endtask : test_thermal
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {serial_clock, serial_data_in, thermal_compare} = '0;
      hsize = 3'h2;
      serial_select_low = 1'b1;
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      test_regs();
      foreach (modes[i])
         test_mix(modes[i]);
      test_offset();
      test_thermal();
      finish_test();
   end
   // run needs about 70 us; allow four times that
   initial begin
      #300000;
      miscompares++;
      finish_test();
   end
endmodule : dual_dac_datapath_test
